// File: txd_pkg.sv
// Shared constants, register map and descriptor layout for the tx descriptor builder
package txd_pkg;

    // ************************************************************
    // Ring geometry
    // ************************************************************
    localparam int RING_DEPTH = 16;
    localparam int IDX_W = 4;
    localparam int DESC_W = 128;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] OFS_ADDR_LO = 8'h00;
    localparam logic [7:0] OFS_ADDR_HI = 8'h04;
    localparam logic [7:0] OFS_LEN_OFS = 8'h08;
    localparam logic [7:0] OFS_CMD_VLAN = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam int CTRL_POST_BIT = 0;
    localparam int CFG_HEAD_WB_BIT = 8;
    localparam int ST_HEAD_LSB = 0;
    localparam int ST_TAIL_LSB = 4;
    localparam int ST_FULL_BIT = 8;
    localparam int ST_EMPTY_BIT = 9;
    localparam int ST_INPKT_BIT = 10;
    localparam int ST_BUSY_BIT = 11;
    localparam int ST_ERR_LSB = 12;

    // ************************************************************
    // Legacy descriptor fields
    // ************************************************************
    localparam int CMD_EOP = 0;
    localparam int CMD_APPEND_FCS_BIT = 1;
    localparam int CMD_IC = 2;
    localparam int CMD_RS = 3;
    localparam int CMD_DESCRIPTOR_EXTENSION_BIT = 5;
    localparam int CMD_VLE = 6;
    localparam int STA_DD = 0;
    localparam int DESCRIPTOR_EXTENSION_BIT_POS = 93;
    localparam logic [15:0] MAX_LEN_BYTES = 16'd15872;

    // ************************************************************
    // Post result codes
    // ************************************************************
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_FULL = 3'h1;
    localparam logic [2:0] ERR_LEN = 3'h2;
    localparam logic [2:0] ERR_NULL = 3'h3;
    localparam logic [2:0] ERR_OFS = 3'h4;

    typedef struct packed {
        logic [63:0] addr;
        logic [15:0] len;
        logic [7:0] checksum_insert_offset;
        logic [7:0] checksum_start_offset;
        logic [7:0] cmd;
        logic [15:0] vlan;
    } txd_req_t;

    typedef struct packed {
        logic [15:0] vlan;
        logic [7:0] checksum_start_offset;
        logic [3:0] rsvd;
        logic [3:0] status_nibble;
        logic [7:0] cmd;
        logic [7:0] checksum_insert_offset;
        logic [15:0] len;
        logic [63:0] addr;
    } txd_desc_t;

    typedef enum logic [1:0] {
        TXD_IDLE = 2'b00,
        TXD_CHECK = 2'b01,
        TXD_WRITE = 2'b11
    } txd_state_t;

endpackage

// File: txd_ring_mem.sv
// Descriptor ring storage with one write port and a registered read port
module txd_ring_mem
    import txd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Write port
    input wire logic we,
    input wire logic [IDX_W-1:0] waddr,
    input wire logic [DESC_W-1:0] wdata,
    // Read port
    input wire logic re,
    input wire logic [IDX_W-1:0] raddr,
    output logic [DESC_W-1:0] rdata_q
);
    logic [DESC_W-1:0] mem [RING_DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
        end else if (re) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

// File: txd_encode.sv
// Builds one legacy descriptor from a request and checks it before posting
module txd_encode
    import txd_pkg::*;
(
    // Request
    input txd_req_t req,
    input wire logic first,
    input wire logic wthresh_zero,
    // Result
    output txd_desc_t desc,
    output logic [2:0] err
);
    wire is_null = (req.len == 16'h0000);
    wire eop = req.cmd[CMD_EOP];
    // Offload bits only mean something on a packet's first buffer
    wire ic = first & req.cmd[CMD_IC];
    wire vlan_insert_bit = first & req.cmd[CMD_VLE];
    wire rs = eop & wthresh_zero;
    wire append_fcs_bit = req.cmd[CMD_APPEND_FCS_BIT] | ic | vlan_insert_bit;

    // Null descriptors only between packets, with end of packet set
    assign err = (req.len > MAX_LEN_BYTES) ? ERR_LEN :
                 (is_null && (!eop || !first)) ? ERR_NULL :
                 (ic && (req.checksum_insert_offset <= req.checksum_start_offset)) ? ERR_OFS : ERR_NONE;

    assign desc.addr = req.addr;
    assign desc.len = req.len;
    // Offsets pass as given on a first buffer and are zero on later ones; caller counts the tag only if it sits in the buffer
    assign desc.checksum_insert_offset = first ? req.checksum_insert_offset : 8'h00;
    assign desc.checksum_start_offset = first ? req.checksum_start_offset : 8'h00;
    // Reserved bits and extension bit stay zero: legacy format
    assign desc.cmd = {1'b0, vlan_insert_bit, 1'b0, 1'b0, rs, ic, append_fcs_bit, eop};
    assign desc.status_nibble = 4'h0;
    assign desc.rsvd = 4'h0;
    // Tag stored high byte first in memory
    assign desc.vlan = vlan_insert_bit ? {req.vlan[7:0], req.vlan[15:8]} : 16'h0000;
endmodule

// File: txd_ctrl.sv
// Host-side legacy transmit descriptor builder with APB control registers
module txd_ctrl
    import txd_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Device ring access
    output logic [IDX_W-1:0] TX_TAIL,
    input wire logic DEV_RD_EN,
    input wire logic [IDX_W-1:0] DEV_RD_IDX,
    output logic [DESC_W-1:0] DEV_RDATA,
    input wire logic DEV_DONE_WE,
    input wire logic [IDX_W-1:0] DEV_DONE_IDX,
    // Device configuration
    output logic [15:0] VLAN_ETHERTYPE,
    output logic [6:0] WRITEBACK_THRESHOLD,
    output logic HEAD_WRITEBACK_ENABLE
);
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [IDX_W-1:0] idx_inc(input logic [IDX_W-1:0] i);
        return IDX_W'(i + 1'b1);
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] addr_lo_q, addr_hi_q, len_ofs_q, cmd_vlan_q, config_q;
    txd_state_t state_q, state_d;
    txd_desc_t desc_q;
    logic [2:0] err_q;
    logic [IDX_W-1:0] tail_q, head_q, rd_idx_q;
    logic [IDX_W:0] count_q, count_d;
    logic [RING_DEPTH-1:0] dd_q;
    logic in_packet_q;

    // ************************************************************
    // APB decode
    // ************************************************************
    wire apb_acc = PSEL & PENABLE;
    wire apb_wr = apb_acc & PWRITE;
    wire hit_addr_lo = (PADDR == OFS_ADDR_LO);
    wire hit_addr_hi = (PADDR == OFS_ADDR_HI);
    wire hit_len_ofs = (PADDR == OFS_LEN_OFS);
    wire hit_cmd_vlan = (PADDR == OFS_CMD_VLAN);
    wire hit_ctrl = (PADDR == OFS_CTRL);
    wire hit_config = (PADDR == OFS_CONFIG);
    wire hit_status = (PADDR == OFS_STATUS);
    wire mapped = hit_addr_lo | hit_addr_hi | hit_len_ofs | hit_cmd_vlan | hit_ctrl
                  | hit_config | hit_status;
    wire post_req = apb_wr & hit_ctrl & PSTRB[0] & PWDATA[CTRL_POST_BIT];

    wire full = (count_q == (IDX_W+1)'(RING_DEPTH));
    wire empty = (count_q == '0);
    wire busy = (state_q != TXD_IDLE);

    logic [31:0] status_word;
    assign status_word = {16'h0000, 1'b0, err_q, busy, in_packet_q, empty, full,
                          tail_q, head_q};

    assign PREADY = 1'b1;
    assign PSLVERR = apb_acc & ~mapped;
    assign PRDATA = !apb_acc ? 32'h0000_0000 :
                    hit_addr_lo ? addr_lo_q :
                    hit_addr_hi ? addr_hi_q :
                    hit_len_ofs ? len_ofs_q :
                    hit_cmd_vlan ? cmd_vlan_q :
                    hit_config ? config_q :
                    hit_status ? status_word : 32'h0000_0000;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_lo_q <= RST_WORD;
            addr_hi_q <= RST_WORD;
            len_ofs_q <= RST_WORD;
            cmd_vlan_q <= RST_WORD;
            config_q <= RST_WORD;
        end else if (apb_wr) begin
            if (hit_addr_lo) addr_lo_q <= merge_bytes(addr_lo_q, PWDATA, PSTRB);
            if (hit_addr_hi) addr_hi_q <= merge_bytes(addr_hi_q, PWDATA, PSTRB);
            if (hit_len_ofs) len_ofs_q <= merge_bytes(len_ofs_q, PWDATA, PSTRB);
            if (hit_cmd_vlan) cmd_vlan_q <= merge_bytes(cmd_vlan_q, PWDATA, PSTRB);
            if (hit_config) config_q <= merge_bytes(config_q, PWDATA, PSTRB);
        end
    end

    // ************************************************************
    // Device configuration pins
    // ************************************************************
    assign VLAN_ETHERTYPE = config_q[31:16];
    assign WRITEBACK_THRESHOLD = config_q[6:0];
    assign HEAD_WRITEBACK_ENABLE = config_q[CFG_HEAD_WB_BIT];

    // ************************************************************
    // Descriptor build
    // ************************************************************
    txd_req_t req;
    txd_desc_t enc_desc;
    logic [2:0] enc_err;
    assign req.addr = {addr_hi_q, addr_lo_q};
    assign req.len = len_ofs_q[15:0];
    assign req.checksum_insert_offset = len_ofs_q[23:16];
    assign req.checksum_start_offset = len_ofs_q[31:24];
    assign req.cmd = cmd_vlan_q[7:0];
    assign req.vlan = cmd_vlan_q[31:16];

    txd_encode u_encode (
        .req(req),
        .first(~in_packet_q),
        .wthresh_zero(WRITEBACK_THRESHOLD == 7'h00),
        .desc(enc_desc),
        .err(enc_err)
    );

    // ************************************************************
    // Post sequencer
    // ************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            TXD_IDLE: begin
                if (post_req) state_d = TXD_CHECK;
            end
            TXD_CHECK: begin
                if (!full && enc_err == ERR_NONE) state_d = TXD_WRITE;
                else state_d = TXD_IDLE;
            end
            TXD_WRITE: state_d = TXD_IDLE;
            default: state_d = TXD_IDLE;
        endcase
    end

    wire do_write = (state_q == TXD_WRITE);
    // Retire every slot up to the reported one
    wire [IDX_W-1:0] done_gap = IDX_W'(idx_inc(DEV_DONE_IDX) - head_q);
    wire [IDX_W:0] freed = !DEV_DONE_WE ? '0 :
                           (done_gap == '0) ? count_q : {1'b0, done_gap};
    assign count_d = count_q - freed + {{IDX_W{1'b0}}, do_write};

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_q <= TXD_IDLE;
            desc_q <= '0;
            err_q <= ERR_NONE;
            tail_q <= '0;
            head_q <= '0;
            count_q <= '0;
            in_packet_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            if (DEV_DONE_WE) head_q <= idx_inc(DEV_DONE_IDX);
            if (state_q == TXD_CHECK) begin
                desc_q <= enc_desc;
                err_q <= full ? ERR_FULL : enc_err;
            end
            if (do_write) begin
                tail_q <= idx_inc(tail_q);
                in_packet_q <= ~desc_q.cmd[CMD_EOP];
            end
        end
    end

    // Done flags: device set wins over the host clearing a reused slot
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dd_q <= '0;
        end else begin
            for (int i = 0; i < RING_DEPTH; i++) begin
                if (DEV_DONE_WE && DEV_DONE_IDX == IDX_W'(i)) dd_q[i] <= 1'b1;
                else if (do_write && tail_q == IDX_W'(i)) dd_q[i] <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Ring storage and device view
    // ************************************************************
    logic [DESC_W-1:0] mem_rdata;
    txd_ring_mem u_mem (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .we(do_write),
        .waddr(tail_q),
        .wdata(desc_q),
        .re(DEV_RD_EN),
        .raddr(DEV_RD_IDX),
        .rdata_q(mem_rdata)
    );

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) rd_idx_q <= '0;
        else if (DEV_RD_EN) rd_idx_q <= DEV_RD_IDX;
    end

    // Status nibble reflects the live done flag, so a re-read sees completion
    assign DEV_RDATA = {mem_rdata[DESC_W-1:97], dd_q[rd_idx_q], mem_rdata[95:0]};
    assign TX_TAIL = tail_q;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    property p_descriptor_extension_bit_clear;
        do_write |-> !desc_q.cmd[CMD_DESCRIPTOR_EXTENSION_BIT] && !mem_rdata[DESCRIPTOR_EXTENSION_BIT_POS] || !DEV_RD_EN;
    endproperty
    a_descriptor_extension_bit_clear: assert property (p_descriptor_extension_bit_clear) else $error("extension bit set");

    property p_rs_on_eop;
        do_write && desc_q.cmd[CMD_RS] |-> desc_q.cmd[CMD_EOP] && WRITEBACK_THRESHOLD == 7'h00;
    endproperty
    a_rs_on_eop: assert property (p_rs_on_eop) else $error("report status misplaced");

    property p_null_between;
        do_write && desc_q.len == 16'h0000 |-> desc_q.cmd[CMD_EOP] && !in_packet_q;
    endproperty
    a_null_between: assert property (p_null_between) else $error("bad null descriptor");

    property p_len_max;
        do_write |-> desc_q.len <= MAX_LEN_BYTES;
    endproperty
    a_len_max: assert property (p_len_max) else $error("length above limit");

    property p_ofs_order;
        do_write && desc_q.cmd[CMD_IC] |-> desc_q.checksum_insert_offset > desc_q.checksum_start_offset;
    endproperty
    a_ofs_order: assert property (p_ofs_order) else $error("insert offset not past start");

    property p_later_clean;
        do_write && in_packet_q |-> desc_q.checksum_insert_offset == 8'h00 && desc_q.checksum_start_offset == 8'h00
            && !desc_q.cmd[CMD_VLE] && !desc_q.cmd[CMD_IC];
    endproperty
    a_later_clean: assert property (p_later_clean) else $error("offload on later buffer");

    property p_fcs_forced;
        do_write && (desc_q.cmd[CMD_IC] || desc_q.cmd[CMD_VLE]) |-> desc_q.cmd[CMD_APPEND_FCS_BIT];
    endproperty
    a_fcs_forced: assert property (p_fcs_forced) else $error("FCS not appended");

    property p_vlan_order;
        state_q == TXD_CHECK && state_d == TXD_WRITE && ~in_packet_q && req.cmd[CMD_VLE]
            |=> desc_q.vlan == {$past(req.vlan[7:0]), $past(req.vlan[15:8])};
    endproperty
    a_vlan_order: assert property (p_vlan_order) else $error("tag byte order wrong");

    property p_done_seen;
        DEV_DONE_WE ##1 DEV_RD_EN && DEV_RD_IDX == $past(DEV_DONE_IDX)
            |=> DEV_RDATA[96 + STA_DD];
    endproperty
    a_done_seen: assert property (p_done_seen) else $error("done bit not visible");

    property p_pkt_track;
        do_write |=> in_packet_q == !$past(desc_q.cmd[CMD_EOP]) && state_q == TXD_IDLE;
    endproperty
    a_pkt_track: assert property (p_pkt_track) else $error("packet tracking wrong");
endmodule

// File: txd_dev_model.sv
// Behavioural device that walks the descriptor ring and reports completion
module txd_dev_model
    import txd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Ring access
    input wire logic go,
    input wire logic head_wb,
    input wire logic [IDX_W-1:0] tail,
    input wire logic [DESC_W-1:0] rdata,
    output logic rd_en,
    output logic [IDX_W-1:0] rd_idx,
    output logic done_we,
    output logic [IDX_W-1:0] done_idx,
    // Observation
    output txd_desc_t last_q,
    output logic legacy_q,
    output int count_q,
    output logic seen_q
);
    timeunit 1ns;
    timeprecision 1ps;

    txd_desc_t desc;
    logic fetch_q, confirm_q;

    assign desc = rdata;

    // ************************************************************
    // Fetch, decode and completion
    // ************************************************************
    // Go low stalls the fetch so posted slots pile up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_en <= 1'b0;
            rd_idx <= '0;
            fetch_q <= 1'b0;
            done_we <= 1'b0;
            done_idx <= '0;
            last_q <= '0;
            legacy_q <= 1'b0;
            count_q <= 0;
            confirm_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            done_we <= 1'b0;
            if (rd_en) begin
                rd_en <= 1'b0;
                fetch_q <= 1'b1;
            end else if (fetch_q) begin
                fetch_q <= 1'b0;
                if (confirm_q) begin
                    // Re-read of a completed slot must show its done flag
                    confirm_q <= 1'b0;
                    seen_q <= rdata[96 + STA_DD];
                    rd_idx <= rd_idx + 1'b1;
                end else begin
                    last_q <= desc;
                    legacy_q <= !rdata[DESCRIPTOR_EXTENSION_BIT_POS];
                    count_q <= count_q + 1;
                    if (desc.cmd[CMD_RS] && !head_wb) begin
                        done_we <= 1'b1;
                        done_idx <= rd_idx;
                        confirm_q <= 1'b1;
                        seen_q <= 1'b0;
                    end else begin
                        rd_idx <= rd_idx + 1'b1;
                    end
                end
            end else if (confirm_q) begin
                // One cycle after the done pulse, read the same slot back
                rd_en <= 1'b1;
            end else if (go && rd_idx != tail) begin
                rd_en <= 1'b1;
            end
        end
    end
endmodule

// File: txd_ctrl_test.sv
// Self-checking bench for the legacy tx descriptor builder
module txd_ctrl_test
    import txd_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        txd_req_t req;
        logic [2:0] err;
    } txd_row_t;

    logic REF_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, go = 1'b0;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rdat;
    logic PREADY, PSLVERR, rerr, rd_en, done_we, legacy, seen, HEAD_WRITEBACK_ENABLE;
    logic [IDX_W-1:0] TX_TAIL, rd_idx, done_idx;
    logic [DESC_W-1:0] DEV_RDATA;
    logic [15:0] VLAN_ETHERTYPE;
    logic [6:0] WRITEBACK_THRESHOLD;
    txd_desc_t last_desc;
    int cnt, n_mismatch = 0, tests_run = 0;
    txd_row_t rows [11];

    always #20 REF_CLK = ~REF_CLK;

    txd_ctrl u_txd_ctrl (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .TX_TAIL(TX_TAIL), .DEV_RD_EN(rd_en),
        .DEV_RD_IDX(rd_idx), .DEV_RDATA(DEV_RDATA), .DEV_DONE_WE(done_we),
        .DEV_DONE_IDX(done_idx), .VLAN_ETHERTYPE(VLAN_ETHERTYPE),
        .WRITEBACK_THRESHOLD(WRITEBACK_THRESHOLD), .HEAD_WRITEBACK_ENABLE(HEAD_WRITEBACK_ENABLE));

    txd_dev_model u_txd_dev_model (.clk(REF_CLK), .arst_n(ARST_N), .go(go),
        .head_wb(HEAD_WRITEBACK_ENABLE), .tail(TX_TAIL), .rdata(DEV_RDATA), .rd_en(rd_en),
        .rd_idx(rd_idx), .done_we(done_we), .done_idx(done_idx), .last_q(last_desc),
        .legacy_q(legacy), .count_q(cnt), .seen_q(seen));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic conclude();
        $display("compares %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask

    // Request held until the rising edge that sees PREADY; answer taken there
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        @(posedge REF_CLK);
        while (PREADY !== 1'b1 && n < 64) begin
            @(posedge REF_CLK);
            n++;
        end
        rdat = PRDATA;
        rerr = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge REF_CLK);
        if (n == 64) begin
            n_mismatch++;
            conclude();
        end
    endtask

    // Busy clears two edges after the post is taken, then status is read
    task automatic post(input txd_req_t r);
        apb(1'b1, OFS_ADDR_LO, r.addr[31:0]);
        apb(1'b1, OFS_ADDR_HI, r.addr[63:32]);
        apb(1'b1, OFS_LEN_OFS, {r.checksum_start_offset, r.checksum_insert_offset, r.len});
        apb(1'b1, OFS_CMD_VLAN, {r.vlan, 8'h00, r.cmd});
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge REF_CLK);
        apb(1'b0, OFS_STATUS, '0);
    endtask

    task automatic wait_fetch(input int c);
        int n;
        n = 0;
        while (cnt == c && n < 64) begin
            @(posedge REF_CLK);
            n++;
        end
        if (cnt == c) begin
            n_mismatch++;
            conclude();
        end
    endtask

    function automatic logic [127:0] exp_desc(input txd_req_t r, input logic f, input logic t0);
        txd_desc_t d;
        logic vlan_insert_bit, ic;
        d = '0;
        vlan_insert_bit = r.cmd[CMD_VLE] & f;
        ic = r.cmd[CMD_IC] & f;
        d.addr = r.addr;
        d.len = r.len;
        d.cmd = {1'b0, vlan_insert_bit, 2'b00, r.cmd[CMD_EOP] & t0, ic, r.cmd[CMD_APPEND_FCS_BIT] | vlan_insert_bit | ic,
                 r.cmd[CMD_EOP]};
        if (f) begin
            d.checksum_insert_offset = r.checksum_insert_offset;
            d.checksum_start_offset = r.checksum_start_offset;
        end
        // Tag only travels when it is to be inserted
        if (vlan_insert_bit) begin
            d.vlan = {r.vlan[7:0], r.vlan[15:8]};
        end
        return d;
    endfunction

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic first;
        logic [IDX_W-1:0] tail;
        int c;
        rows = '{
            '{'{64'h0000_0001_0000_0010, 16'd64, 8'h24, 8'h10, 8'h05, 16'h0000}, ERR_NONE},
            '{'{64'h0000_0000_0000_2000, 16'd100, 8'h00, 8'h00, 8'h40, 16'habcd}, ERR_NONE},
            '{'{64'h0000_0000_0000_3003, 16'd50, 8'h30, 8'h10, 8'h01, 16'h0000}, ERR_NONE},
            '{'{64'hffff_0000_0000_0001, 16'd15872, 8'h00, 8'h00, 8'h03, 16'h0000}, ERR_NONE},
            '{'{64'h0000_0000_0000_4000, 16'd15873, 8'h00, 8'h00, 8'h01, 16'h0000}, ERR_LEN},
            '{'{64'h0000_0000_0000_5000, 16'd0, 8'h00, 8'h00, 8'h01, 16'h0000}, ERR_NONE},
            '{'{64'h0000_0000_0000_6000, 16'd0, 8'h00, 8'h00, 8'h00, 16'h0000}, ERR_NULL},
            '{'{64'h0000_0000_0000_7000, 16'd40, 8'h10, 8'h10, 8'h05, 16'h0000}, ERR_OFS},
            '{'{64'h0000_0000_0000_8000, 16'd20, 8'h20, 8'h08, 8'h04, 16'h0000}, ERR_NONE},
            '{'{64'h0000_0000_0000_9000, 16'd0, 8'h00, 8'h00, 8'h01, 16'h0000}, ERR_NULL},
            '{'{64'h0000_0000_0000_a000, 16'd8, 8'h30, 8'h01, 8'h01, 16'h0000}, ERR_NONE}};
        repeat (3) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        @(posedge REF_CLK);
        apb(1'b0, OFS_STATUS, '0);
        chk(rdat, 32'h0000_0200);
        apb(1'b0, OFS_CONFIG, '0);
        chk({rdat, TX_TAIL, PREADY}, {RST_WORD, 4'h0, 1'b1});
        $display("test reset done");
        go <= 1'b1;
        first = 1'b1;
        tail = '0;
        foreach (rows[i]) begin
            c = cnt;
            post(rows[i].req);
            chk(rdat[14:12], rows[i].err);
            if (rows[i].err === ERR_NONE) begin
                wait_fetch(c);
                chk(last_desc, exp_desc(rows[i].req, first, 1'b1));
                chk(legacy, 1'b1);
                tail = tail + 1'b1;
                first = rows[i].req.cmd[CMD_EOP];
            end
            chk(TX_TAIL, tail);
            $display("test %0d done", i);
        end
        repeat (4) @(posedge REF_CLK);
        apb(1'b0, OFS_STATUS, '0);
        chk(rdat[11:0], {4'h2, tail, tail});
        chk(seen, 1'b1);
        // Unmapped word and write-only control
        apb(1'b1, 8'h1c, 32'hffff_ffff);
        chk(rerr, 1'b1);
        apb(1'b0, 8'h1c, '0);
        chk({rerr, rdat}, {1'b1, 32'h0});
        apb(1'b0, OFS_CTRL, '0);
        chk({rerr, rdat}, 33'h0);
        $display("test regs done");
        apb(1'b1, OFS_CONFIG, 32'h88a8_0102);
        chk({VLAN_ETHERTYPE, HEAD_WRITEBACK_ENABLE, WRITEBACK_THRESHOLD}, 24'h88a8_82);
        c = cnt;
        post(rows[0].req);
        wait_fetch(c);
        chk(last_desc, exp_desc(rows[0].req, 1'b1, 1'b0));
        tail = tail + 1'b1;
        $display("test threshold done");
        // Stalled device still lets the host post, then reset mid-run
        go <= 1'b0;
        post(rows[3].req);
        tail = tail + 1'b1;
        chk({TX_TAIL, cnt}, {tail, c + 1});
        ARST_N <= 1'b0;
        @(posedge REF_CLK);
        chk({TX_TAIL, VLAN_ETHERTYPE, HEAD_WRITEBACK_ENABLE, WRITEBACK_THRESHOLD}, '0);
        // Release again, read status, then post: everything must restart clean
        repeat (2) @(posedge REF_CLK);
        ARST_N <= 1'b1;
        go <= 1'b1;
        @(posedge REF_CLK);
        apb(1'b0, OFS_STATUS, '0);
        chk(rdat, 32'h0000_0200);
        c = cnt;
        post(rows[0].req);
        wait_fetch(c);
        chk(last_desc, exp_desc(rows[0].req, 1'b1, 1'b1));
        chk(TX_TAIL, 4'h1);
        $display("test midrun reset done");
        conclude();
    end
endmodule
